// *** logic/dmme_pkg.sv ***
`default_nettype none
package dmme_pkg;
  // kind of instruction cycle now running
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_MOVE2,
    ST_SKIP1,
    ST_SKIP2
  } dmme_state_t;

  // four phases of one instruction cycle, one clock each
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // opcode prefixes
  localparam logic [3:0] OP_MOVE_SRC = 4'hC;
  localparam logic [3:0] OP_MOVE_DST = 4'hF;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [7:0] OP_LOAD_ACC = 8'h0E;
  localparam logic [7:0] OP_MULTIPLY = 8'h0D;
  localparam logic [6:0] OP_STORE = 7'h37;
  localparam logic [15:0] INSTR_NOP = 16'h0000;

  // data space map
  localparam logic [11:0] ACC_DATA_ADDR = 12'hFE8;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_ADDR = 12'h000;
endpackage
`default_nettype wire

// *** logic/dmme_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module dmme_core (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // program memory side
  input wire logic [15:0] instrWord,
  input wire logic skipIn,
  // data memory side
  input wire logic [7:0] dataRdData,
  output logic [11:0] dataAddr_reg,
  output logic dataRdEn_reg,
  output logic dataWrEn_reg,
  output logic [7:0] dataWrData_reg,
  // core registers
  output logic [7:0] acc_reg,
  output logic [7:0] bankSelect_reg,
  output logic [7:0] productHigh_reg,
  output logic [7:0] productLow_reg,
  output logic [1:0] phase_reg
);

  function automatic logic [11:0] mapFile(input logic access,
                                          input logic [7:0] f,
                                          input logic [7:0] bank);
    logic [3:0] hi;
    hi = (f < dmme_pkg::ACCESS_SPLIT) ? dmme_pkg::ACCESS_LOW_BANK
                                      : dmme_pkg::ACCESS_HIGH_BANK;
    mapFile = access ? {bank[3:0], f} : {hi, f};
  endfunction

  function automatic logic [15:0] mult(input logic [7:0] a,
                                       input logic [7:0] b);
    // widen first so the upper byte of the product is never lost
    mult = {8'h00, a} * {8'h00, b};
  endfunction

  dmme_pkg::dmme_state_t state_reg, state_next;
  logic [15:0] instr_reg, instr_next;
  logic [7:0] moveByte_reg;

  // decode of the word in hand
  wire inExec = (state_reg == dmme_pkg::ST_EXEC);
  wire inMove2 = (state_reg == dmme_pkg::ST_MOVE2);
  wire isMoveSrc = inExec && (instr_reg[15:12] == dmme_pkg::OP_MOVE_SRC);
  wire moveDstOk = inMove2 && (instr_reg[15:12] == dmme_pkg::OP_MOVE_DST);
  wire isLoadBank = inExec && (instr_reg[15:8] == dmme_pkg::OP_LOAD_BANK);
  wire isLoadAcc = inExec && (instr_reg[15:8] == dmme_pkg::OP_LOAD_ACC);
  wire isMultiply = inExec && (instr_reg[15:8] == dmme_pkg::OP_MULTIPLY);
  wire isStore = inExec && (instr_reg[15:9] == dmme_pkg::OP_STORE);
  wire srcIsAcc = (instr_reg[11:0] == dmme_pkg::ACC_DATA_ADDR);
  wire dstIsAcc = moveDstOk && srcIsAcc;
  wire [11:0] storeAddr = mapFile(instr_reg[8], instr_reg[7:0],
                                  bankSelect_reg);
  wire [15:0] product = mult(acc_reg, instr_reg[7:0]);
  wire incomingMove = (instrWord[15:12] == dmme_pkg::OP_MOVE_SRC);

  // write planned for Q4 of this cycle
  wire wrNext = isStore || (moveDstOk && !dstIsAcc);
  wire [11:0] wrAddr = isStore ? storeAddr : instr_reg[11:0];
  wire [7:0] wrData = isStore ? acc_reg : moveByte_reg;

  // next cycle kind, taken at the end of Q4
  always_comb begin
    state_next = dmme_pkg::ST_EXEC;
    instr_next = skipIn ? dmme_pkg::INSTR_NOP : instrWord;
    case (state_reg)
      dmme_pkg::ST_EXEC: begin
        if (isMoveSrc) begin
          state_next = dmme_pkg::ST_MOVE2;
          instr_next = instrWord;
        end else if (skipIn && incomingMove) begin
          state_next = dmme_pkg::ST_SKIP1;
        end
      end
      dmme_pkg::ST_SKIP1: begin
        // second word must never run as an instruction
        state_next = dmme_pkg::ST_SKIP2;
        instr_next = dmme_pkg::INSTR_NOP;
      end
      dmme_pkg::ST_MOVE2: state_next = dmme_pkg::ST_EXEC;
      dmme_pkg::ST_SKIP2: state_next = dmme_pkg::ST_EXEC;
      default: state_next = dmme_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= dmme_pkg::PH_Q1;
    end else begin
      phase_reg <= phase_reg + dmme_pkg::PH_STEP;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= dmme_pkg::ST_EXEC;
      instr_reg <= dmme_pkg::INSTR_NOP;
    end else if (phase_reg == dmme_pkg::PH_Q4) begin
      state_reg <= state_next;
      instr_reg <= instr_next;
    end
  end

  // data port: source read in Q2, write in Q4
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dataAddr_reg <= dmme_pkg::RST_ADDR;
      dataRdEn_reg <= 1'b0;
      dataWrEn_reg <= 1'b0;
      dataWrData_reg <= dmme_pkg::RST_BYTE;
    end else begin
      case (phase_reg)
        dmme_pkg::PH_Q1: begin
          dataAddr_reg <= instr_reg[11:0];
          dataRdEn_reg <= isMoveSrc && !srcIsAcc;
        end
        dmme_pkg::PH_Q2: dataRdEn_reg <= 1'b0;
        dmme_pkg::PH_Q3: begin
          dataWrEn_reg <= wrNext;
          dataAddr_reg <= wrAddr;
          dataWrData_reg <= wrData;
        end
        dmme_pkg::PH_Q4: dataWrEn_reg <= 1'b0;
        default: dataWrEn_reg <= 1'b0;
      endcase
    end
  end

  // source byte; the accumulator stands in for its own address
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      moveByte_reg <= dmme_pkg::RST_BYTE;
    end else if (phase_reg == dmme_pkg::PH_Q2 && isMoveSrc) begin
      moveByte_reg <= srcIsAcc ? acc_reg : dataRdData;
    end
  end

  // core register writes at the end of Q4; no flags exist here to touch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= dmme_pkg::RST_BYTE;
      bankSelect_reg <= dmme_pkg::RST_BYTE;
      productHigh_reg <= dmme_pkg::RST_BYTE;
      productLow_reg <= dmme_pkg::RST_BYTE;
    end else if (phase_reg == dmme_pkg::PH_Q4) begin
      if (isLoadAcc) acc_reg <= instr_reg[7:0];
      else if (dstIsAcc) acc_reg <= moveByte_reg;
      if (isLoadBank) bankSelect_reg <= instr_reg[7:0];
      if (isMultiply) begin
        productHigh_reg <= product[15:8];
        productLow_reg <= product[7:0];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_move_second: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isMoveSrc) |=>
      state_reg == dmme_pkg::ST_MOVE2 && instr_reg == $past(instrWord))
    else $error("move first word not followed by second");

  a_move_copy: assert property (
    (dataWrEn_reg && inMove2) |->
      dataAddr_reg == instr_reg[11:0] && dataWrData_reg == moveByte_reg)
    else $error("move wrote wrong address or byte");

  a_move_timing: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isMoveSrc) |=>
      inMove2 ##3 (phase_reg == dmme_pkg::PH_Q4 &&
                   (dataWrEn_reg || !moveDstOk || dstIsAcc)))
    else $error("move destination not written in second Q4");

  a_read_phase: assert property (
    dataRdEn_reg |-> phase_reg == dmme_pkg::PH_Q2 && !srcIsAcc)
    else $error("source read outside Q2");

  a_acc_dest: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && dstIsAcc) |=>
      acc_reg == $past(moveByte_reg) && !dataWrEn_reg)
    else $error("move to accumulator address failed");

  a_bank_load: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isLoadBank) |=>
      bankSelect_reg == $past(instr_reg[7:0]))
    else $error("bank select not loaded");

  a_acc_load: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isLoadAcc) |=>
      acc_reg == $past(instr_reg[7:0]))
    else $error("accumulator literal not loaded");

  a_store_data: assert property (
    (dataWrEn_reg && isStore) |->
      dataWrData_reg == acc_reg ##1 $stable(acc_reg))
    else $error("store wrote wrong data");

  a_mult_result: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isMultiply) |=>
      {productHigh_reg, productLow_reg} ==
        {8'h00, $past(acc_reg)} * {8'h00, $past(instr_reg[7:0])})
    else $error("product pair wrong");

  a_mult_keeps_acc: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && isMultiply) |=> $stable(acc_reg))
    else $error("multiply changed accumulator");

  a_access_map: assert property (
    (dataWrEn_reg && isStore && !instr_reg[8]) |->
      dataAddr_reg[11:8] == (instr_reg[7] ? dmme_pkg::ACCESS_HIGH_BANK
                                          : dmme_pkg::ACCESS_LOW_BANK))
    else $error("access bank mapping wrong");

  a_skip_quiet: assert property (
    (phase_reg == dmme_pkg::PH_Q4 && state_reg == dmme_pkg::ST_SKIP1) |=>
      (state_reg == dmme_pkg::ST_SKIP2 && !dataWrEn_reg && !dataRdEn_reg)[*4])
    else $error("skipped move second word executed");

  c_move: cover property (dataWrEn_reg && inMove2);
  c_skip_move: cover property (state_reg == dmme_pkg::ST_SKIP2);
  c_multiply: cover property (phase_reg == dmme_pkg::PH_Q4 && isMultiply);

endmodule
`default_nettype wire

// *** sim/dmme_data_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module dmme_data_mem (
  // clock
  input wire logic clk_sys,
  // data memory side
  input wire logic [11:0] dataAddr_reg,
  input wire logic dataRdEn_reg,
  input wire logic dataWrEn_reg,
  input wire logic [7:0] dataWrData_reg,
  output logic [7:0] dataRdData
);
  logic [7:0] mem [0:4095];
  logic [7:0] lastRd = 8'h00;
  // no strobe: inverse of last byte, so stale data never passes as valid
  assign dataRdData = dataRdEn_reg ? mem[dataAddr_reg] : ~lastRd;
  always @(posedge clk_sys) begin
    if (dataRdEn_reg)
      lastRd <= mem[dataAddr_reg];
    if (dataWrEn_reg)
      mem[dataAddr_reg] <= dataWrData_reg;
  end
endmodule
`default_nettype wire

// *** sim/data_move_multiply_exec_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module data_move_multiply_exec_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic skipIn = 1'b0;
  logic [7:0] rdData, wrData, acc, bank, product_high, product_low;
  logic [11:0] addr;
  logic rdEn, wrEn;
  logic [1:0] phase;
  int n_mismatch = 0;
  int samples_checked = 0;
  // instruction, then expected accumulator, bank and product
  logic [47:0] rows [8] = '{48'h0E5A_5A00_0000, 48'h0105_5A05_0000,
    48'h0EE2_E205_0000, 48'h0DC4_E205_AD08, 48'h0D00_E205_0000,
    48'h010F_E20F_0000, 48'h0EFF_FF0F_0000, 48'h0DFF_FF0F_FE01};
  logic [27:0] stRows [3] = '{28'h6E10_010, 28'h6E90_F90, 28'h6F20_F20};

  dmme_core i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .instrWord(instrWord), .skipIn(skipIn), .dataRdData(rdData),
    .dataAddr_reg(addr), .dataRdEn_reg(rdEn), .dataWrEn_reg(wrEn),
    .dataWrData_reg(wrData), .acc_reg(acc), .bankSelect_reg(bank),
    .productHigh_reg(product_high), .productLow_reg(product_low), .phase_reg(phase));
  dmme_data_mem i_mem (.clk_sys(clk_sys), .dataAddr_reg(addr),
    .dataRdEn_reg(rdEn), .dataWrEn_reg(wrEn), .dataWrData_reg(wrData),
    .dataRdData(rdData));

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one program word per slot, taken at the edge ending phase 3
  task automatic slot(input logic [15:0] w, input logic s);
    int i;
    for (i = 0; i < 8 && phase !== 2'h3; i++)
      @(posedge clk_sys) #1;
    if (phase !== 2'h3) begin
      n_mismatch++;
      summarize();
    end
    instrWord = w;
    skipIn = s;
    @(posedge clk_sys) #1;
    instrWord = 16'h0000;
    skipIn = 1'b0;
  endtask

  // destinations never name counter or stack bytes
  task automatic mv(input logic [11:0] src, input logic [11:0] dst);
    slot({4'hC, src}, 1'b0);
    slot({4'hF, dst}, 1'b0);
    slot(16'h0000, 1'b0);
  endtask

  initial begin
    int r;
    for (r = 0; r < 4096; r++)
      i_mem.mem[r] = 8'hAA;
    i_mem.mem[12'h123] = 8'h33;
    i_mem.mem[12'hFFF] = 8'h5C;
    repeat (8) @(posedge clk_sys);
    chk({acc, bank}, 16'h0000);
    chk({product_high, product_low}, 16'h0000);
    chk({12'h000, wrEn, rdEn, phase}, 16'h0000);
    #1 resetn = 1'b1;
    $display("reset test done");
    for (r = 0; r < 8; r++) begin
      slot(rows[r][47:32], 1'b0);
      slot(16'h0000, 1'b0);
      chk({acc, bank}, rows[r][31:16]);
      chk({product_high, product_low}, rows[r][15:0]);
    end
    $display("literal rows done");
    for (r = 0; r < 3; r++) begin
      slot(stRows[r][27:12], 1'b0);
      slot(16'h0000, 1'b0);
      chk(i_mem.mem[stRows[r][11:0]], 16'h00FF);
    end
    chk({acc, bank}, 16'hFF0F);
    $display("store test done");
    slot(16'hC123, 1'b0);
    slot(16'hF456, 1'b0);
    chk(i_mem.mem[12'h456], 16'h00AA);
    slot(16'h0000, 1'b0);
    chk(i_mem.mem[12'h456], 16'h0033);
    mv(12'hFFF, 12'h000);
    chk(i_mem.mem[12'h000], 16'h005C);
    mv(12'hFE8, 12'h300);
    chk(i_mem.mem[12'h300], 16'h00FF);
    mv(12'h123, 12'hFE8);
    chk({8'h00, acc}, 16'h0033);
    $display("move test done");
    slot(16'hC123, 1'b1);
    slot(16'hF201, 1'b0);
    slot(16'h0E11, 1'b0);
    slot(16'h0000, 1'b0);
    chk(i_mem.mem[12'h201], 16'h00AA);
    chk({8'h00, acc}, 16'h0011);
    slot(16'hC123, 1'b1);
    slot(16'h0E77, 1'b0);
    slot(16'h0000, 1'b0);
    chk({8'h00, acc}, 16'h0011);
    slot(16'h0E99, 1'b1);
    slot(16'h0000, 1'b0);
    chk({8'h00, acc}, 16'h0011);
    $display("skip test done");
    summarize();
  end
endmodule
`default_nettype wire
